// ### rtl/rmt_pkg.sv
// Package with register map, field layout, reset values and timing constants of the receive timers.
//
// Overview of operation
// - After each transmission ends, receiver output is masked for the programmed window.
// - Mask duration equals the 8-bit mask value times 64 carrier periods.
// - Mask values zero to four all give the minimum of four steps.
// - In bit rate detection mode one mask step lasts 512 carrier periods.
// - In 106 kbit/s type A mode the mask is lengthened by a fixed 20 carrier periods.
// - Response window elapsing without a response raises the no-response interrupt.
// - Timeout step is 64 carrier periods, or 4096 when step select is set.
// - Timeout value is 16 bits wide; upper byte held in its own register.
// - In active communication mode the timer starts after external field appears, or at once on the start-timer command.
// - Outside active communication mode the timeout timer starts automatically when the transmitter switches off.
// - A zero timeout value never starts the timer and never interrupts.
// - The start-timer command resets the timeout timer and restarts it.
// - Mask value resets to eight, timeout upper byte to zero, also on set-default.
// - Auto squelch starts once four mask steps have passed, ends at mask expiry.
package rmt_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_MASK_TIME   = 8'h0e;
    localparam logic [7:0] IDX_RESP_HIGH   = 8'h0f;
    localparam logic [7:0] IDX_RESP_LOW    = 8'h10;
    localparam logic [7:0] IDX_CTRL        = 8'h11;
    localparam logic [7:0] IDX_COMMAND     = 8'h20;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h21;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h22;
    // Control register fields.
    localparam int CTRL_STEP_SEL    = 0;
    localparam int CTRL_ACTIVE_MODE = 1;
    localparam int CTRL_RATE_DETECT = 2;
    localparam int CTRL_TYPE_A106   = 3;
    localparam int CTRL_AUTO_SQUELCH = 4;
    localparam int CTRL_W           = 5;
    // Command register fields (self clearing; a read returns the mask run flag in bit 4 and the timeout run flag in bit 5).
    localparam int CMD_START_RESP   = 0;
    localparam int CMD_SET_DEFAULT  = 1;
    // Interrupt status fields.
    localparam int IRQ_NO_RESPONSE  = 0;
    localparam int IRQ_MASK_DONE    = 1;
    localparam int IRQ_W            = 2;
    // Reset values.
    localparam logic [7:0] MASK_TIME_RST = 8'h08;
    localparam logic [7:0] RESP_HIGH_RST = 8'h00;
    localparam logic [7:0] RESP_LOW_RST  = 8'h00;
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    // Step lengths in carrier periods; STEP_LONG is the last count of the 4096-period step.
    localparam int PRE_W            = 12;
    localparam logic [PRE_W-1:0] STEP_SHORT  = 12'h040;
    localparam logic [PRE_W-1:0] STEP_DETECT = 12'h200;
    localparam logic [PRE_W-1:0] STEP_LONG   = 12'hfff;
    localparam logic [7:0] MASK_MIN_STEPS = 8'h04;
    // Fixed part of the type A frame delay, added as carrier periods.
    localparam logic [PRE_W-1:0] A106_EXTRA = 12'h014;
endpackage

// ### rtl/rmt_timers.sv
// Mask receive timer and no-response timer with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module rmt_timers (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Framing logic, same clock.
    input  wire logic        carrier_tick,
    input  wire logic        tx_end,
    input  wire logic        rx_response,
    input  wire logic        rx_in,
    // External field detector pin.
    input  wire logic        ext_field,
    // Receiver side outputs.
    output logic             rx_out,
    output logic             squelch,
    output logic             mask_active,
    output logic             resp_active,
    output logic             irq
);
    typedef struct packed {
        logic [7:0]                   mask_time;
        logic [7:0]                   resp_high;
        logic [7:0]                   resp_low;
        logic [rmt_pkg::CTRL_W-1:0]   ctrl;
        logic [rmt_pkg::IRQ_W-1:0]    irq_st;
        logic [rmt_pkg::IRQ_W-1:0]    irq_msk;
        logic                         a_we;
        logic [7:0]                   a_idx;
        logic [31:0]                  rdata;
        logic                         m_run;
        logic [rmt_pkg::PRE_W-1:0]    m_pre;
        logic [7:0]                   m_step;
        logic [7:0]                   m_target;
        logic                         n_arm;
        logic                         n_run;
        logic [rmt_pkg::PRE_W-1:0]    n_pre;
        logic [15:0]                  n_step;
        logic                         fs1;
        logic                         fs2;
        logic                         fld_q;
    } rmt_state_s;

    rmt_state_s st;
    rmt_state_s next_st;

    // Read decode, used by the address phase.
    function automatic logic [31:0] rmt_read(input rmt_state_s s, input logic [7:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (idx)
            rmt_pkg::IDX_MASK_TIME:  v = {24'h000000, s.mask_time};
            rmt_pkg::IDX_RESP_HIGH:  v = {24'h000000, s.resp_high};
            rmt_pkg::IDX_RESP_LOW:   v = {24'h000000, s.resp_low};
            rmt_pkg::IDX_CTRL:       v = {27'h0000000, s.ctrl};
            rmt_pkg::IDX_IRQ_STATUS: v = {30'h00000000, s.irq_st};
            rmt_pkg::IDX_IRQ_MASK:   v = {30'h00000000, s.irq_msk};
            rmt_pkg::IDX_COMMAND:    v = {26'h0000000, s.n_run, s.m_run, 4'h0};
            default:                 v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Step length of the mask timer for the current mode.
    function automatic logic [rmt_pkg::PRE_W-1:0] rmt_mask_step(input logic [rmt_pkg::CTRL_W-1:0] c);
        return c[rmt_pkg::CTRL_RATE_DETECT] ? rmt_pkg::STEP_DETECT : rmt_pkg::STEP_SHORT;
    endfunction

    logic        addr_ok;
    logic        wr_data;
    logic [15:0] resp_val;
    logic        cmd_start;
    logic        cmd_dflt;
    logic        fld_rise;
    logic        n_start;
    logic        m_last;
    logic        n_last;
    logic [rmt_pkg::PRE_W-1:0] n_len;
    logic [rmt_pkg::IRQ_W-1:0] ev;

    // Combined next-state logic.
    always_comb begin
        next_st   = st;
        addr_ok   = hsel && hready && htrans[1];
        wr_data   = st.a_we;
        resp_val  = {st.resp_high, st.resp_low};
        cmd_start = wr_data && (st.a_idx == rmt_pkg::IDX_COMMAND) && hwdata[rmt_pkg::CMD_START_RESP];
        cmd_dflt  = wr_data && (st.a_idx == rmt_pkg::IDX_COMMAND) && hwdata[rmt_pkg::CMD_SET_DEFAULT];
        ev        = '0;

        // Bus address phase; reads are answered from a flip-flop in the data phase, no wait states.
        next_st.a_we  = addr_ok && hwrite;
        next_st.a_idx = haddr[9:2];
        if (addr_ok && !hwrite) begin
            next_st.rdata = rmt_read(st, haddr[9:2]);
        end

        // Register writes in the data phase.
        if (wr_data) begin
            case (st.a_idx)
                rmt_pkg::IDX_MASK_TIME: next_st.mask_time = hwdata[7:0];
                rmt_pkg::IDX_RESP_HIGH: next_st.resp_high = hwdata[7:0];
                rmt_pkg::IDX_RESP_LOW:  next_st.resp_low  = hwdata[7:0];
                rmt_pkg::IDX_CTRL:      next_st.ctrl      = hwdata[rmt_pkg::CTRL_W-1:0];
                rmt_pkg::IDX_IRQ_MASK:  next_st.irq_msk   = hwdata[rmt_pkg::IRQ_W-1:0];
                rmt_pkg::IDX_IRQ_STATUS: next_st.irq_st   = st.irq_st & ~hwdata[rmt_pkg::IRQ_W-1:0];
                default: begin
                end
            endcase
        end
        if (cmd_dflt) begin
            next_st.mask_time = rmt_pkg::MASK_TIME_RST;
            next_st.resp_high = rmt_pkg::RESP_HIGH_RST;
            next_st.resp_low  = rmt_pkg::RESP_LOW_RST;
        end

        // External field detector passes two flip-flops before its edge is taken.
        next_st.fs1   = ext_field;
        next_st.fs2   = st.fs1;
        next_st.fld_q = st.fs2;
        fld_rise      = st.fs2 && !st.fld_q;

        // Mask timer: each end of transmission reloads it, short values are raised to four steps.
        m_last = carrier_tick && (st.m_pre == rmt_mask_step(st.ctrl) - 12'h001);
        if (tx_end) begin
            next_st.m_run    = 1'b1;
            next_st.m_step   = 8'h00;
            next_st.m_pre    = st.ctrl[rmt_pkg::CTRL_TYPE_A106] ? (12'h000 - rmt_pkg::A106_EXTRA) : 12'h000;
            next_st.m_target = (st.mask_time <= rmt_pkg::MASK_MIN_STEPS) ? rmt_pkg::MASK_MIN_STEPS
                                                                          : st.mask_time;
        end else if (st.m_run && carrier_tick) begin
            // A106 preload runs the prescaler from below zero, so its wrap is tested on the full width.
            next_st.m_pre = m_last ? 12'h000 : st.m_pre + 12'h001;
            if (m_last && !(st.ctrl[rmt_pkg::CTRL_TYPE_A106] && st.m_pre[rmt_pkg::PRE_W-1])) begin
                next_st.m_step = st.m_step + 8'h01;
                if (st.m_step + 8'h01 == st.m_target) begin
                    next_st.m_run = 1'b0;
                    ev[rmt_pkg::IRQ_MASK_DONE] = 1'b1;
                end
            end
        end

        // No-response timer start conditions.
        n_len   = st.ctrl[rmt_pkg::CTRL_STEP_SEL] ? rmt_pkg::STEP_LONG : (rmt_pkg::STEP_SHORT - 12'h001);
        n_last  = carrier_tick && (st.n_pre == n_len);
        n_start = 1'b0;
        if (tx_end) begin
            if (st.ctrl[rmt_pkg::CTRL_ACTIVE_MODE]) begin
                next_st.n_arm = 1'b1;
            end else begin
                n_start = 1'b1;
            end
        end else if (st.n_arm && fld_rise) begin
            next_st.n_arm = 1'b0;
            n_start       = 1'b1;
        end
        if (cmd_start) begin
            n_start       = 1'b1;
            next_st.n_arm = 1'b0;
        end

        // Count timeout steps; a detected response stops the window.
        if (n_start) begin
            next_st.n_run  = (resp_val != 16'h0000);
            next_st.n_pre  = '0;
            next_st.n_step = 16'h0000;
        end else if (st.n_run && rx_response) begin
            next_st.n_run = 1'b0;
        end else if (st.n_run && carrier_tick) begin
            next_st.n_pre = n_last ? 12'h000 : st.n_pre + 12'h001;
            if (n_last) begin
                next_st.n_step = st.n_step + 16'h0001;
                if (st.n_step + 16'h0001 == resp_val) begin
                    next_st.n_run = 1'b0;
                    ev[rmt_pkg::IRQ_NO_RESPONSE] = 1'b1;
                end
            end
        end
        if (rx_response) begin
            next_st.n_arm = 1'b0;
        end

        // Sticky status; a new event wins over a clear in the same cycle.
        next_st.irq_st = next_st.irq_st | ev;
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st           <= '0;
            st.mask_time <= rmt_pkg::MASK_TIME_RST;
            st.resp_high <= rmt_pkg::RESP_HIGH_RST;
            st.resp_low  <= rmt_pkg::RESP_LOW_RST;
            st.ctrl      <= rmt_pkg::CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs; the receiver is blanked while the mask window runs.
    assign hrdata      = st.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign mask_active = st.m_run;
    assign rx_out      = rx_in && !st.m_run;
    assign squelch     = st.ctrl[rmt_pkg::CTRL_AUTO_SQUELCH] && st.m_run
                         && (st.m_step >= rmt_pkg::MASK_MIN_STEPS);
    assign resp_active = st.n_run;
    assign irq         = |(st.irq_st & st.irq_msk);

endmodule

// ### verification/rmt_chk.sv
// Concurrent checks of the receive timer block, bound to its ports.
`timescale 1ns/10ps
module rmt_chk (
    // Clock, reset and bus answer.
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    // Framing side.
    input wire logic carrier_tick,
    input wire logic tx_end,
    input wire logic rx_response,
    input wire logic rx_in,
    // Receiver side.
    input wire logic rx_out,
    input wire logic mask_active,
    input wire logic resp_active
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [19:0] ticks;
    // Carrier steps of the current mask window; a new end of transmission starts it again.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ticks <= 20'h00000;
        else if (tx_end)
            ticks <= 20'h00000;
        else if (carrier_tick && mask_active)
            ticks <= ticks + 20'h00001;
    end
    // A counter only moves on a carrier step, so a window may end one or two cycles after one.
    sequence s_tick_seen;
        $past(carrier_tick) || $past(carrier_tick, 2);
    endsequence
    sequence s_resp_hit;
        resp_active && rx_response && !tx_end;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
    AST_RX_BLANK: assert property (mask_active |-> !rx_out) else $error("receiver output not blanked");
    AST_RX_PASS: assert property (!mask_active |-> rx_out == rx_in) else $error("receiver output not passed");
    AST_MASK_START: assert property (tx_end |=> mask_active) else $error("mask did not start");
    AST_MASK_FLOOR: assert property ($fell(mask_active) |-> ticks >= 20'd256) else $error("mask too short");
    AST_MASK_TICK: assert property ($fell(mask_active) |-> s_tick_seen) else $error("mask ended off step");
    AST_RESP_STOP: assert property (s_resp_hit |=> !resp_active) else $error("reply did not stop timer");
    AST_RESP_TICK: assert property ($fell(resp_active) && !$past(rx_response) |-> s_tick_seen)
        else $error("timeout ended off step");
endmodule
bind rmt_timers rmt_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .carrier_tick(carrier_tick),
    .tx_end(tx_end), .rx_response(rx_response), .rx_in(rx_in), .rx_out(rx_out), .mask_active(mask_active),
    .resp_active(resp_active)
);

// ### verification/rmt_framer.sv
// Model of the transmit and receive framing logic that feeds the timer block.
`timescale 1ns/10ps
module rmt_framer (
    // Clock, reset and requests from the bench.
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic send,
    input  wire logic [31:0] reply_dly,
    // Framing outputs.
    output logic      carrier_tick,
    output logic      tx_end,
    output logic      rx_response,
    output logic      rx_in
);
    logic [1:0] div;
    int         wait_cnt;
    // Carrier runs free at a quarter of the bus clock; receiver data is noise so blanking shows.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= 2'h0;
            carrier_tick <= 1'b0;
            tx_end <= 1'b0;
            rx_response <= 1'b0;
            rx_in <= 1'b0;
            wait_cnt <= 0;
        end else begin
            div <= div + 2'h1;
            carrier_tick <= (div == 2'h3);
            rx_in <= 1'($urandom_range(1));
            tx_end <= send;
            rx_response <= (wait_cnt == 1);
            wait_cnt <= send ? int'(reply_dly) : (wait_cnt > 0 ? wait_cnt - 1 : 0);
        end
    end
endmodule

// ### verification/rx_mask_and_no_response_timers_tb.sv
// Self-checking bench of the receive timer block with its framing partner.
`timescale 1ns/10ps
module rx_mask_and_no_response_timers_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, send = 1'b0, fld = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, carrier_tick, tx_end, rx_response, rx_in, rx_out, squelch, mask_active;
    logic        resp_active, irq;
    int          reply_dly = 0, fails = 0, samples_checked = 0, mt = 0, rt = 0, sq = 0;
    always #10 hclk = ~hclk;
    rmt_timers dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .carrier_tick(carrier_tick), .tx_end(tx_end), .rx_response(rx_response), .rx_in(rx_in), .ext_field(fld),
        .rx_out(rx_out), .squelch(squelch), .mask_active(mask_active), .resp_active(resp_active), .irq(irq)
    );
    rmt_framer u_framer (
        .hclk(hclk), .hresetn(hresetn), .send(send), .reply_dly(reply_dly), .carrier_tick(carrier_tick),
        .tx_end(tx_end), .rx_response(rx_response), .rx_in(rx_in)
    );
    // Carrier steps spent in each window, counted independently of the design.
    always @(posedge hclk) begin
        if (carrier_tick && mask_active) mt++;
        if (carrier_tick && resp_active) rt++;
        if (carrier_tick && squelch) sq++;
    end
    task chk(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Single AHB-Lite transfer; the wait on hready guards against any stall.
    task xfer(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function automatic int mask_ticks(logic [7:0] v, logic [4:0] c);
        return (v < 8'h04 ? 4 : int'(v)) * (c[2] ? 512 : 64) + (c[3] ? 20 : 0);
    endfunction
    // One window: program, start by end of transmission or command, wait, compare steps, status and irq.
    task go(input logic [4:0] c, input logic [7:0] v, lo, input logic cmd, input int dly);
        int em, er;
        em = cmd ? 0 : mask_ticks(v, c);
        er = (dly > 0) ? -1 : int'(lo) * (c[0] ? 4096 : 64);
        xfer(1'b1, 32'h38, {24'h0, v});
        xfer(1'b1, 32'h40, {24'h0, lo});
        xfer(1'b1, 32'h44, {27'h0, c});
        reply_dly = dly;
        mt = 0;
        rt = 0;
        sq = 0;
        if (cmd) xfer(1'b1, 32'h80, 32'h1);
        else begin
            @(posedge hclk) send <= 1'b1;
            @(posedge hclk) send <= 1'b0;
        end
        // In active mode the timeout must wait for the outside field before it runs.
        if (c[1]) begin
            repeat (40) @(posedge hclk);
            chk(resp_active, 1'b0);
            fld <= 1'b1;
        end
        repeat (5) @(posedge hclk);
        for (int i = 0; i < 20000 && (mask_active || resp_active); i++) @(posedge hclk);
        fld <= 1'b0;
        chk(mt, em);
        if (er >= 0) chk(rt, er);
        chk(sq, c[4] ? em - 256 : 0);
        xfer(1'b0, 32'h84, 32'h0);
        chk(rd[1:0], {~cmd, er > 0});
        chk(irq, {~cmd, er > 0} != 2'h0);
        xfer(1'b1, 32'h88, 32'h0);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        xfer(1'b1, 32'h88, 32'h3);
        xfer(1'b1, 32'h84, 32'h3);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        logic [7:0] v;
        v = 8'($urandom(32'hb765f184));
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, 32'h38, 32'h0);
        chk(rd, 32'h8);
        xfer(1'b0, 32'h3fc, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, 32'h3c, {24'h0, v});
        xfer(1'b0, 32'h3c, 32'h0);
        chk(rd, {24'h0, v});
        xfer(1'b1, 32'h38, 32'h55);
        xfer(1'b1, 32'h80, 32'h2);
        xfer(1'b0, 32'h38, 32'h0);
        chk(rd, 32'h8);
        xfer(1'b0, 32'h3c, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b1, 32'h88, 32'h3);
        for (int i = 0; i < 6; i++) begin
            go(5'h00, i == 5 ? 8'($urandom_range(5, 12)) : 8'(i), 8'($urandom_range(1, 3)), 0, 0);
        end
        go(5'h04, 8'h04, 8'h01, 1'b0, 0);
        go(5'h08, 8'h05, 8'h01, 1'b0, 0);
        go(5'h01, 8'h06, 8'h01, 1'b0, 0);
        go(5'h10, 8'h08, 8'h00, 1'b0, 0);
        go(5'h02, 8'h04, 8'h01, 1'b0, 0);
        go(5'h00, 8'h04, 8'h03, 1'b0, 100);
        go(5'h00, 8'h04, 8'h02, 1'b1, 0);
        test_done;
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #1500000;
        fails++;
        test_done;
    end
endmodule
